// File: rtl/dcsp_top.sv
/*
  One DMA channel's size registers and progress pointers behind an
  Avalon-MM slave. The data mover outside pulses byte events; this block
  tracks where the channel is and when source, destination, cell and
  block are done.
  Assumes event inputs come from logic on i_mclk, one pulse per byte.
*/
`timescale 1ns/1ns
module dcsp_top
  import dcsp_pkg::*;
(
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // avalon-mm slave
  input wire logic [DCSP_AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [DCSP_DW-1:0] i_avs_writedata,
  output logic [DCSP_DW-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // byte events from the mover
  input wire logic i_trigger,
  input wire logic i_src_byte,
  input wire logic i_dest_byte,
  input wire logic i_pattern_match,
  // status to the mover
  output logic o_busy,
  output logic o_src_done,
  output logic o_dest_done,
  output logic o_cell_done,
  output logic o_block_done,
  output logic [DCSP_LW-1:0] o_src_progress,
  output logic [DCSP_LW-1:0] o_dest_progress
);
  typedef struct packed {
    dcsp_state_e state;
    logic [DCSP_DW-1:0] rdata;
    logic [DCSP_LW-1:0] src_length;
    logic [DCSP_LW-1:0] dest_length;
    logic [DCSP_LW-1:0] cell_length;
    logic [DCSP_LW-1:0] cell_progress;
    logic [DCSP_LW:0] block_count;
    logic enable;
    logic pat_mode;
    logic in_cell;
    logic [DCSP_NFLAG-1:0] flags;
    logic [DCSP_NFLAG-1:0] pulses;
  } dcsp_top_s;

  dcsp_top_s st_r, st_nxt;
  dcsp_avm_req_s req;
  dcsp_evt_s evt;
  logic [DCSP_LW-1:0] src_progress;
  logic [DCSP_LW-1:0] dest_progress;
  logic src_hit, dest_hit, src_step, dest_step, pat_clear, blk_end, cell_end;
  logic [DCSP_LW:0] blk_len;

  // widens a length to 17 bits, zero meaning 65,536
  function automatic logic [DCSP_LW:0] full_len(input logic [DCSP_LW-1:0] len);
    full_len = (len == DCSP_LEN_RST) ? {1'b1, DCSP_LEN_RST} : {1'b0, len};
  endfunction

  // pads a 16-bit field; upper half reads zero
  function automatic logic [DCSP_DW-1:0] pad16(input logic [DCSP_LW-1:0] v);
    pad16 = {{(DCSP_DW-DCSP_LW){1'b0}}, v};
  endfunction

  assign req = '{address: i_avs_address, read: i_avs_read, write: i_avs_write,
                 writedata: i_avs_writedata};
  assign evt = '{trigger: i_trigger, rd_ack: i_src_byte, wr_ack: i_dest_byte,
                 match: i_pattern_match};

  assign pat_clear = st_r.pat_mode && evt.match && st_r.in_cell;
  assign src_step = st_r.in_cell && evt.rd_ack;
  assign dest_step = st_r.in_cell && evt.wr_ack;

  dcsp_len_cmp u_src (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_clear(pat_clear || blk_end),
    .i_step(src_step),
    .i_length(st_r.src_length),
    .o_progress(src_progress),
    .o_done(src_hit)
  );

  dcsp_len_cmp u_dest (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_clear(blk_end),
    .i_step(dest_step),
    .i_length(st_r.dest_length),
    .o_progress(dest_progress),
    .o_done(dest_hit)
  );

  // block spans the larger of the two lengths, counted on destination writes
  assign blk_len = (full_len(st_r.src_length) > full_len(st_r.dest_length)) ?
                   full_len(st_r.src_length) : full_len(st_r.dest_length);
  assign blk_end = (dest_step && ((st_r.block_count + 17'h00001) == blk_len)) || pat_clear;
  assign cell_end = dest_step &&
                    ({1'b0, st_r.cell_progress} + 17'h00001 == full_len(st_r.cell_length));

  always_comb begin
    st_nxt = st_r;
    st_nxt.pulses = '0;
    // trigger opens a cell only while enabled and not already moving
    if (st_r.enable && evt.trigger && !st_r.in_cell) begin
      st_nxt.in_cell = 1'b1;
    end
    if (dest_step) begin
      st_nxt.cell_progress = st_r.cell_progress + DCSP_ONE;
      st_nxt.block_count = st_r.block_count + 17'h00001;
    end
    if (cell_end || blk_end) begin
      st_nxt.in_cell = 1'b0;
      st_nxt.cell_progress = DCSP_LEN_RST;
    end
    if (pat_clear) begin
      st_nxt.cell_progress = DCSP_LEN_RST;
    end
    if (blk_end) begin
      st_nxt.block_count = '0;
    end
    // bus side: one cycle of wait, answer on the second
    case (st_r.state)
      DCSP_IDLE: begin
        if (req.read) begin
          st_nxt.state = DCSP_READ;
          if (req.address == DCSP_OFF_SRC_SIZE) begin
            st_nxt.rdata = pad16(st_r.src_length);
          end else if (req.address == DCSP_OFF_DEST_SIZE) begin
            st_nxt.rdata = pad16(st_r.dest_length);
          end else if (req.address == DCSP_OFF_SRC_PTR) begin
            st_nxt.rdata = pad16(src_progress);
          end else if (req.address == DCSP_OFF_DEST_PTR) begin
            st_nxt.rdata = pad16(dest_progress);
          end else if (req.address == DCSP_OFF_CELL_SIZE) begin
            st_nxt.rdata = pad16(st_r.cell_length);
          end else if (req.address == DCSP_OFF_CTRL) begin
            st_nxt.rdata = DCSP_UNMAPPED;
            st_nxt.rdata[DCSP_CTRL_EN] = st_r.enable;
            st_nxt.rdata[DCSP_CTRL_PAT] = st_r.pat_mode;
          end else if (req.address == DCSP_OFF_STATUS) begin
            st_nxt.rdata = DCSP_UNMAPPED;
            st_nxt.rdata[DCSP_NFLAG-1:0] = st_r.flags;
            st_nxt.rdata[DCSP_ST_BUSY] = st_r.in_cell;
          end else if (req.address == DCSP_OFF_CELL_PTR) begin
            st_nxt.rdata = pad16(st_r.cell_progress);
          end else begin
            st_nxt.rdata = DCSP_UNMAPPED;
          end
        end else if (req.write) begin
          st_nxt.state = DCSP_WRITE;
        end
      end
      // a write lands only at the edge where waitrequest is seen low
      DCSP_WRITE: begin
        st_nxt.state = DCSP_IDLE;
        if (req.write) begin
          if (req.address == DCSP_OFF_SRC_SIZE) begin
            st_nxt.src_length = req.writedata[DCSP_LW-1:0];
          end else if (req.address == DCSP_OFF_DEST_SIZE) begin
            st_nxt.dest_length = req.writedata[DCSP_LW-1:0];
          end else if (req.address == DCSP_OFF_CELL_SIZE) begin
            st_nxt.cell_length = req.writedata[DCSP_LW-1:0];
          end else if (req.address == DCSP_OFF_CTRL) begin
            st_nxt.enable = req.writedata[DCSP_CTRL_EN];
            st_nxt.pat_mode = req.writedata[DCSP_CTRL_PAT];
          end else if (req.address == DCSP_OFF_STATUS) begin
            st_nxt.flags = st_r.flags & ~req.writedata[DCSP_NFLAG-1:0];
          end
        end
      end
      default: begin
        st_nxt.state = DCSP_IDLE;
      end
    endcase
    // hardware set wins over software clear in the same cycle
    if (blk_end) begin
      st_nxt.flags[DCSP_ST_BLOCK] = 1'b1;
      st_nxt.pulses[DCSP_ST_BLOCK] = 1'b1;
    end
    if (src_hit) begin
      st_nxt.flags[DCSP_ST_SRC] = 1'b1;
      st_nxt.pulses[DCSP_ST_SRC] = 1'b1;
    end
    if (dest_hit) begin
      st_nxt.flags[DCSP_ST_DEST] = 1'b1;
      st_nxt.pulses[DCSP_ST_DEST] = 1'b1;
    end
    if (cell_end) begin
      st_nxt.flags[DCSP_ST_CELL] = 1'b1;
      st_nxt.pulses[DCSP_ST_CELL] = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_avs_readdata = st_r.rdata;
  assign o_avs_waitrequest = (st_r.state == DCSP_IDLE);
  assign o_busy = st_r.in_cell;
  assign o_block_done = st_r.pulses[DCSP_ST_BLOCK];
  assign o_src_done = st_r.pulses[DCSP_ST_SRC];
  assign o_dest_done = st_r.pulses[DCSP_ST_DEST];
  assign o_cell_done = st_r.pulses[DCSP_ST_CELL];
  assign o_src_progress = src_progress;
  assign o_dest_progress = dest_progress;
endmodule

// File: rtl/dcsp_pkg.sv
/*
  Package for the DMA channel size and progress-pointer block: register map,
  field layout, reset values, state enum, bus and event carrier structs.
  Assumes a 32-bit Avalon-MM slave with word addressing in bytes.
  // Function
  // - destination length is 16 bits; zero means 65,536 bytes
  // - cell length is 16 bits per trigger event; zero means 65,536 bytes
  // - read-only 16-bit source progress shows current source byte index
  // - in pattern-detect mode a pattern match clears source progress
  // - read-only 16-bit destination progress shows current destination byte index
  // - upper sixteen bits of size and pointer registers read zero
  // - reset clears destination size, cell size and both pointers
  // - source length is 16 bits; zero means 65,536 bytes
  // - block completes after larger length moved or on pattern match; set flag
  // - source done when pointer reaches source length; same for destination
*/
package dcsp_pkg;
  localparam int DCSP_AW = 6;
  localparam int DCSP_LW = 16;
  localparam int DCSP_DW = 32;
  localparam logic [DCSP_AW-1:0] DCSP_OFF_SRC_SIZE = 6'h00;
  localparam logic [DCSP_AW-1:0] DCSP_OFF_DEST_SIZE = 6'h04;
  localparam logic [DCSP_AW-1:0] DCSP_OFF_SRC_PTR = 6'h08;
  localparam logic [DCSP_AW-1:0] DCSP_OFF_DEST_PTR = 6'h0C;
  localparam logic [DCSP_AW-1:0] DCSP_OFF_CELL_SIZE = 6'h10;
  localparam logic [DCSP_AW-1:0] DCSP_OFF_CTRL = 6'h14;
  localparam logic [DCSP_AW-1:0] DCSP_OFF_STATUS = 6'h18;
  localparam logic [DCSP_AW-1:0] DCSP_OFF_CELL_PTR = 6'h1C;
  localparam logic [DCSP_LW-1:0] DCSP_LEN_RST = 16'h0000;
  localparam logic [DCSP_LW-1:0] DCSP_ONE = 16'h0001;
  localparam logic [DCSP_DW-1:0] DCSP_UNMAPPED = 32'h0000_0000;
  // control bit positions
  localparam int DCSP_CTRL_EN = 0;
  localparam int DCSP_CTRL_PAT = 1;
  // status bit positions: the four flags write one to clear; busy is read-only
  localparam int DCSP_ST_BLOCK = 0;
  localparam int DCSP_ST_SRC = 1;
  localparam int DCSP_ST_DEST = 2;
  localparam int DCSP_ST_CELL = 3;
  localparam int DCSP_ST_BUSY = 4;
  localparam int DCSP_NFLAG = 4;

  typedef enum logic [1:0] {DCSP_IDLE, DCSP_READ, DCSP_WRITE} dcsp_state_e;

  typedef struct packed {
    logic [DCSP_AW-1:0] address;
    logic read;
    logic write;
    logic [DCSP_DW-1:0] writedata;
  } dcsp_avm_req_s;

  typedef struct packed {
    logic [DCSP_DW-1:0] readdata;
    logic waitrequest;
  } dcsp_avm_rsp_s;

  typedef struct packed {
    logic trigger;
    logic rd_ack;
    logic wr_ack;
    logic match;
  } dcsp_evt_s;
endpackage

// File: rtl/dcsp_len_cmp.sv
/*
  Progress counter for one side of the channel: steps once per byte,
  wraps at the programmed length and flags when the length is reached.
  Assumes steps and clears come from logic on the same clock.
*/
`timescale 1ns/1ns
module dcsp_len_cmp
  import dcsp_pkg::*;
(
  // clock and control
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_clear,
  input wire logic i_step,
  // programmed length, zero meaning full range
  input wire logic [DCSP_LW-1:0] i_length,
  // progress
  output logic [DCSP_LW-1:0] o_progress,
  output logic o_done
);
  typedef struct packed {
    logic [DCSP_LW-1:0] ptr;
  } dcsp_cnt_s;
  dcsp_cnt_s st_r, st_nxt;
  logic last;

  // zero length wraps naturally at 65,535 + 1
  assign last = ((st_r.ptr + DCSP_ONE) == i_length);

  always_comb begin
    st_nxt = st_r;
    if (i_clear) begin
      st_nxt.ptr = DCSP_LEN_RST;
    end else if (i_step) begin
      st_nxt.ptr = last ? DCSP_LEN_RST : st_r.ptr + DCSP_ONE;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_progress = st_r.ptr;
  assign o_done = i_step && last;
endmodule

// File: tb/dcsp_monitor.sv
/* Assertions on the channel's ports: bus handshake, pointers, done pulses.
   Assumes bind to dcsp_top and a steady high i_ce in the bench. */
`timescale 1ns/1ns
module dcsp_monitor
  import dcsp_pkg::*;
(
  input wire logic i_mclk, i_rst, i_ce, i_avs_read, i_avs_write,
  input wire logic [DCSP_AW-1:0] i_avs_address,
  input wire logic [DCSP_DW-1:0] i_avs_writedata, o_avs_readdata,
  input wire logic o_avs_waitrequest, o_busy, o_src_done, o_dest_done, o_block_done,
  input wire logic i_src_byte, i_dest_byte, i_pattern_match,
  input wire logic [DCSP_LW-1:0] o_src_progress, o_dest_progress
);
  logic [DCSP_LW-1:0] src_len_r, dst_len_r;
  logic pat_r;
  // shadow of written lengths; zero widened to 65,536 for the max
  wire logic [16:0] src_eff = {src_len_r == 16'h0000, src_len_r};
  wire logic [16:0] dst_eff = {dst_len_r == 16'h0000, dst_len_r};
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      src_len_r <= 16'h0000;
      dst_len_r <= 16'h0000;
      pat_r <= 1'b0;
    end else if (i_avs_write && !o_avs_waitrequest && i_ce) begin
      if (i_avs_address == DCSP_OFF_SRC_SIZE) src_len_r <= i_avs_writedata[15:0];
      if (i_avs_address == DCSP_OFF_DEST_SIZE) dst_len_r <= i_avs_writedata[15:0];
      if (i_avs_address == DCSP_OFF_CTRL) pat_r <= i_avs_writedata[DCSP_CTRL_PAT];
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_take;
    (i_avs_read || i_avs_write) && o_avs_waitrequest && i_ce;
  endsequence
  sequence s_ans;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  a_bus_answer: assert property (s_take |=> s_ans)
    else $error("bus answer not one cycle after request");
  a_bus_idle: assert property (!(i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> o_avs_waitrequest) else $error("answer without request");
  a_read_upper: assert property (
    !o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0000) else $error("upper bits set");
  a_src_step: assert property (i_src_byte && o_busy && i_ce |=>
    o_src_progress == $past(o_src_progress) + DCSP_ONE || o_src_progress == 16'h0000)
    else $error("source pointer step wrong");
  a_dest_step: assert property (i_dest_byte && o_busy && i_ce |=>
    o_dest_progress == $past(o_dest_progress) + DCSP_ONE || o_dest_progress == 16'h0000)
    else $error("destination pointer step wrong");
  a_pat_clear: assert property (pat_r && i_pattern_match && o_busy && i_ce |=>
    o_src_progress == 16'h0000) else $error("pattern match kept source pointer");
  a_src_done: assert property (i_src_byte && o_busy && i_ce &&
    o_src_progress + DCSP_ONE == src_len_r |=> o_src_done && o_src_progress == 16'h0000)
    else $error("source done missing");
  a_dest_done: assert property (i_dest_byte && o_busy && i_ce &&
    o_dest_progress + DCSP_ONE == dst_len_r |=> o_dest_done && o_dest_progress == 16'h0000)
    else $error("destination done missing");
  a_block_len: assert property (i_dest_byte && o_busy && i_ce && dst_eff >= src_eff &&
    o_dest_progress + DCSP_ONE == dst_len_r |=> o_block_done) else $error("block not ended");
  a_block_ptr: assert property (o_block_done |->
    o_src_progress == 16'h0000 && o_dest_progress == 16'h0000) else $error("pointers kept");
  a_block_pulse: assert property (o_block_done |=> !o_block_done)
    else $error("block pulse too long");
endmodule
bind dcsp_top dcsp_monitor mon (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_address(i_avs_address),
  .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_busy(o_busy), .o_src_done(o_src_done),
  .o_dest_done(o_dest_done), .o_block_done(o_block_done), .i_src_byte(i_src_byte),
  .i_dest_byte(i_dest_byte), .i_pattern_match(i_pattern_match),
  .o_src_progress(o_src_progress), .o_dest_progress(o_dest_progress));

// File: tb/dcsp_mover.sv
/* Data mover model: one pulse per byte read or written.
   Assumes the caller holds off until the channel is busy. */
`timescale 1ns/1ns
module dcsp_mover (
  // clock
  input wire logic i_mclk,
  // byte pulses to the channel
  output logic o_src_byte,
  output logic o_dest_byte
);
  initial begin
    o_src_byte = 1'b0;
    o_dest_byte = 1'b0;
  end
  // gap models a slow bus; zero gives the densest legal pulse train
  task automatic move(input int ns, input int nd, input int gap);
    for (int i = 0; i < ns || i < nd; i++) begin
      @(posedge i_mclk);
      o_src_byte <= (i < ns);
      o_dest_byte <= (i < nd);
      @(posedge i_mclk);
      o_src_byte <= 1'b0;
      o_dest_byte <= 1'b0;
      repeat (gap) @(posedge i_mclk);
    end
  endtask
endmodule

// File: tb/dcsp_top_tb.sv
/* Self-checking bench for the channel: register map over Avalon-MM and
   pointer progress driven by the mover model. Assumes dcsp_monitor bound. */
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("Error %0t: got %h expected %h", $time, (a), (e)); end end
module dcsp_top_tb;
  import dcsp_pkg::*;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_trigger = 1'b0, i_pattern_match = 1'b0;
  dcsp_avm_req_s req = '0;
  dcsp_avm_rsp_s rsp;
  wire logic [31:0] rdata_w;
  wire logic wait_w, src_b, dst_b, blk, cdone;
  logic [31:0] exp_v;
  logic [31:0] x = 32'h0000_0038, v;
  logic [31:0] exp_q[$];
  int num_errors = 0, n_checks = 0, cyc = 0, nblk = 0, ncell = 0;
  dcsp_top uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(1'b1),
    .i_avs_address(req.address), .i_avs_read(req.read), .i_avs_write(req.write),
    .i_avs_writedata(req.writedata), .o_avs_readdata(rdata_w),
    .o_avs_waitrequest(wait_w), .i_trigger(i_trigger), .i_src_byte(src_b),
    .i_dest_byte(dst_b), .i_pattern_match(i_pattern_match), .o_busy(), .o_src_done(),
    .o_dest_done(), .o_cell_done(cdone), .o_block_done(blk), .o_src_progress(),
    .o_dest_progress());
  dcsp_mover mover (.i_mclk(i_mclk), .o_src_byte(src_b), .o_dest_byte(dst_b));
  assign rsp = '{readdata: rdata_w, waitrequest: wait_w};
  initial forever #4 i_mclk = ~i_mclk;
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task tally_and_finish;
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // a read notes d as the expected word; the watcher compares it
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    req <= '{address: a, read: !w, write: w, writedata: d};
    if (!w) exp_q.push_back(d);
    do @(posedge i_mclk); while (rsp.waitrequest !== 1'b0);
    req <= '0;
  endtask
  task pulse_trig;
    @(posedge i_mclk) i_trigger <= 1'b1;
    @(posedge i_mclk) i_trigger <= 1'b0;
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      tally_and_finish;
    end
    if (blk === 1'b1) nblk++;
    if (cdone === 1'b1) ncell++;
    // pop once: the compare macro evaluates its expected argument twice
    if (req.read && rsp.waitrequest === 1'b0) begin
      exp_v = exp_q.pop_front();
      `CHK(rsp.readdata, exp_v)
    end
  end
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (int i = 1; i < 5; i++) bus(0, 6'(i * 4), 32'h0000_0000);
    bus(1, 6'h3C, rnd());
    bus(0, 6'h3C, 32'h0000_0000);
    bus(1, DCSP_OFF_DEST_SIZE, 32'hFFFF_0005);
    bus(0, DCSP_OFF_DEST_SIZE, 32'h0000_0005);
    v = rnd();
    bus(1, DCSP_OFF_CELL_SIZE, v);
    bus(0, DCSP_OFF_CELL_SIZE, {16'h0000, v[15:0]});
    bus(1, DCSP_OFF_CELL_SIZE, 32'h0000_0000);
    bus(0, DCSP_OFF_CELL_SIZE, 32'h0000_0000);
    bus(1, DCSP_OFF_SRC_PTR, 32'hFFFF_FFFF);
    bus(0, DCSP_OFF_SRC_PTR, 32'h0000_0000);
    bus(1, DCSP_OFF_SRC_SIZE, 32'h0000_0003);
    bus(1, DCSP_OFF_CTRL, 32'h0000_0001);
    pulse_trig();
    mover.move(2, 2, int'(rnd() % 3));
    bus(0, DCSP_OFF_SRC_PTR, 32'h0000_0002);
    bus(0, DCSP_OFF_DEST_PTR, 32'h0000_0002);
    mover.move(1, 1, int'(rnd() % 3));
    bus(0, DCSP_OFF_SRC_PTR, 32'h0000_0000);
    bus(0, DCSP_OFF_DEST_PTR, 32'h0000_0003);
    mover.move(0, 2, 0);
    bus(0, DCSP_OFF_DEST_PTR, 32'h0000_0000);
    `CHK(nblk, 1)
    bus(1, DCSP_OFF_CTRL, 32'h0000_0003);
    pulse_trig();
    mover.move(2, 0, int'(rnd() % 3));
    bus(0, DCSP_OFF_SRC_PTR, 32'h0000_0002);
    @(posedge i_mclk) i_pattern_match <= 1'b1;
    @(posedge i_mclk) i_pattern_match <= 1'b0;
    bus(0, DCSP_OFF_SRC_PTR, 32'h0000_0000);
    `CHK(nblk, 2)
    bus(0, DCSP_OFF_STATUS, 32'h0000_0007);
    bus(1, DCSP_OFF_STATUS, 32'h0000_0003);
    bus(1, DCSP_OFF_CTRL, 32'h0000_0001);
    bus(1, DCSP_OFF_CELL_SIZE, 32'h0000_0002);
    pulse_trig();
    mover.move(0, 1, 0);
    bus(0, DCSP_OFF_CELL_PTR, 32'h0000_0001);
    bus(0, DCSP_OFF_STATUS, 32'h0000_0014);
    mover.move(0, 1, 0);
    bus(0, DCSP_OFF_CELL_PTR, 32'h0000_0000);
    bus(0, DCSP_OFF_STATUS, 32'h0000_000C);
    `CHK(ncell, 1)
    tally_and_finish;
  end
endmodule
